// file: sbst_pkg.sv
// constants, types and state encodings shared by both ends of the boundary-scan link
package sbst_pkg;

  localparam int IR_W  = 3;
  localparam int BSR_W = 75;
  localparam int ID_W  = 32;

  localparam logic [IR_W-1:0] INS_EXTEST   = 3'h0;
  localparam logic [IR_W-1:0] INS_IDCODE   = 3'h1;
  localparam logic [IR_W-1:0] INS_SAMPLE_Z = 3'h2;
  localparam logic [IR_W-1:0] INS_SAMPLE   = 3'h4;
  localparam logic [IR_W-1:0] INS_BYPASS   = 3'h7;
  localparam logic [IR_W-1:0] IR_CAPTURE   = 3'h1;

  // arbitrary neutral identity value, bit 0 set as presence marker
  localparam logic [ID_W-1:0] ID_DEFAULT = 32'h0a5a_5001;

  localparam int RESET_TMS_EDGES = 5;

  // host timing: link clock from the core clock by a divider
  localparam int CORE_PERIOD_NS    = 20;
  localparam int TCK_MIN_PERIOD_NS = 100;
  localparam int TCK_HALF_MIN      = (TCK_MIN_PERIOD_NS + 2 * CORE_PERIOD_NS - 1) / (2 * CORE_PERIOD_NS);
  // returned serial data needs this many core cycles through its synchroniser
  localparam int SYNC_LAT        = 5;
  localparam int TCK_HALF_CYCLES = (TCK_HALF_MIN > SYNC_LAT) ? TCK_HALF_MIN : SYNC_LAT;

  // host walk patterns, lsb first, from run-test/idle
  localparam logic [5:0] PRE_RESET = 6'h1f;
  localparam logic [2:0] LEN_RESET = 3'h6;
  localparam logic [5:0] PRE_DR    = 6'h01;
  localparam logic [2:0] LEN_DR    = 3'h3;
  localparam logic [5:0] PRE_IR    = 6'h03;
  localparam logic [2:0] LEN_IR    = 3'h4;
  localparam logic [1:0] POST_PAT  = 2'h1;
  localparam logic [1:0] LEN_POST  = 2'h2;

  typedef enum logic [1:0] {
    SBST_OP_RESET,
    SBST_OP_IR,
    SBST_OP_DR
  } sbst_op_t;

  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE,
    ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR, ST_PAUSE_DR, ST_EXIT2_DR, ST_UPD_DR,
    ST_SEL_IR, ST_CAP_IR, ST_SHIFT_IR, ST_EXIT1_IR, ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
  } sbst_tap_t;

endpackage : sbst_pkg

// file: sbst_if.sv
// link wires between the test controller and the scan port, pull-ups resolved here
`timescale 1ns/1ps
`default_nettype none
interface sbst_if;
  logic tck;
  logic tms_drv;
  logic tms_oe;
  logic tdi_drv;
  logic tdi_oe;
  logic tdo_drv;
  logic tdo_oe;
  wire  tms;
  wire  tdi;
  wire  tdo;

  // undriven lines float high through the pull-ups
  assign tms = tms_oe ? tms_drv : 1'b1;
  assign tdi = tdi_oe ? tdi_drv : 1'b1;
  assign tdo = tdo_oe ? tdo_drv : 1'b1;

  modport dev (
    input  tck,
    input  tms,
    input  tdi,
    output tdo_drv,
    output tdo_oe
  );

  modport host (
    output tck,
    output tms_drv,
    output tms_oe,
    output tdi_drv,
    output tdi_oe,
    input  tdo,
    input  tdo_oe
  );
endinterface : sbst_if
`default_nettype wire

// file: sbst_tap.sv
// scan port of the memory: controller, instruction, bypass, boundary and identity registers
`timescale 1ns/1ps
`default_nettype none
module sbst_tap #(
  parameter logic [sbst_pkg::ID_W-1:0] ID_VALUE = sbst_pkg::ID_DEFAULT
) (
  input  wire logic                       sys_rst_i,
  input  wire logic [sbst_pkg::BSR_W-1:0] ring_i,
  output var  logic                       mem_hiz_o,
  output var  logic [sbst_pkg::IR_W-1:0]  instr_o,
  sbst_if.dev                             link
);
  import sbst_pkg::*;

  sbst_tap_t               state;
  sbst_tap_t               next_state;
  logic [IR_W-1:0]         ir;
  logic [IR_W-1:0]         ir_sh;
  logic                    byp;
  logic [BSR_W-1:0]        bsr_sh;
  logic [ID_W-1:0]         id_sh;
  logic [BSR_W-1:0]        ring_s1;
  logic [BSR_W-1:0]        ring_s2;
  logic [BSR_W-1:0]        ring_s3;
  logic [BSR_W-1:0]        ring_q;
  logic                    tdo_r;
  logic                    tdo_oe_r;

  // controller transition, one step per rising test clock
  function automatic sbst_tap_t tap_next(input sbst_tap_t s, input logic m);
    case (s)
      ST_RESET:    tap_next = m ? ST_RESET    : ST_IDLE;
      ST_IDLE:     tap_next = m ? ST_SEL_DR   : ST_IDLE;
      ST_SEL_DR:   tap_next = m ? ST_SEL_IR   : ST_CAP_DR;
      ST_CAP_DR:   tap_next = m ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR: tap_next = m ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR: tap_next = m ? ST_UPD_DR   : ST_PAUSE_DR;
      ST_PAUSE_DR: tap_next = m ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR: tap_next = m ? ST_UPD_DR   : ST_SHIFT_DR;
      ST_UPD_DR:   tap_next = m ? ST_SEL_DR   : ST_IDLE;
      ST_SEL_IR:   tap_next = m ? ST_RESET    : ST_CAP_IR;
      ST_CAP_IR:   tap_next = m ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR: tap_next = m ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR: tap_next = m ? ST_UPD_IR   : ST_PAUSE_IR;
      ST_PAUSE_IR: tap_next = m ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR: tap_next = m ? ST_UPD_IR   : ST_SHIFT_IR;
      ST_UPD_IR:   tap_next = m ? ST_SEL_DR   : ST_IDLE;
      default:     tap_next = ST_RESET;
    endcase
  endfunction : tap_next

  // instruction decode
  wire logic sel_bsr;
  wire logic sel_id;
  wire logic sel_byp;
  wire logic hiz_dec;
  wire logic in_shift_dr;
  wire logic in_shift_ir;
  wire logic in_cap_dr;
  wire logic in_cap_ir;
  wire logic in_upd_ir;
  wire logic in_reset;
  wire logic shifting;
  wire logic next_tdo;

  assign next_state  = tap_next(state, link.tms);
  // the three ring-capture instructions all pick the chain; only capture, never drive
  assign sel_bsr     = (ir == INS_EXTEST) || (ir == INS_SAMPLE) || (ir == INS_SAMPLE_Z);
  assign sel_id      = (ir == INS_IDCODE);
  assign sel_byp     = !sel_bsr && !sel_id;
  assign hiz_dec     = (ir == INS_EXTEST) || (ir == INS_SAMPLE_Z);
  assign in_shift_dr = (state == ST_SHIFT_DR);
  assign in_shift_ir = (state == ST_SHIFT_IR);
  assign in_cap_dr   = (state == ST_CAP_DR);
  assign in_cap_ir   = (state == ST_CAP_IR);
  assign in_upd_ir   = (state == ST_UPD_IR);
  assign in_reset    = (state == ST_RESET);
  assign shifting    = in_shift_dr || in_shift_ir;
  // exactly one source feeds the serial output
  assign next_tdo    = in_shift_ir ? ir_sh[0] :
                       sel_bsr     ? bsr_sh[0] :
                       sel_id      ? id_sh[0] : byp;

  // controller state; five high edges from anywhere land in reset
  always_ff @(posedge link.tck) begin
    if (sys_rst_i) begin
      state <= ST_RESET;
    end else begin
      state <= next_state;
    end
  end

  // instruction shift stage, loaded with the fixed pattern at capture
  always_ff @(posedge link.tck) begin
    if (sys_rst_i) begin
      ir_sh <= IR_CAPTURE;
    end else if (in_cap_ir) begin
      ir_sh <= IR_CAPTURE;
    end else if (in_shift_ir) begin
      ir_sh <= {link.tdi, ir_sh[IR_W-1:1]};
    end
  end

  // active instruction; a half-shifted code never reaches the decoder
  always_ff @(posedge link.tck) begin
    if (sys_rst_i) begin
      ir <= INS_IDCODE;
    end else if (in_reset) begin
      ir <= INS_IDCODE;
    end else if (in_upd_ir) begin
      ir <= ir_sh;
    end
  end

  // bypass bit: cleared at capture, one cell of delay while shifting
  always_ff @(posedge link.tck) begin
    if (sys_rst_i) begin
      byp <= 1'b0;
    end else if (sel_byp && in_cap_dr) begin
      byp <= 1'b0;
    end else if (sel_byp && in_shift_dr) begin
      byp <= link.tdi;
    end
  end

  // boundary chain; update-dr is deliberately absent since preload is not built
  always_ff @(posedge link.tck) begin
    if (sys_rst_i) begin
      bsr_sh <= '0;
    end else if (sel_bsr && in_cap_dr) begin
      bsr_sh <= ring_q;
    end else if (sel_bsr && in_shift_dr) begin
      bsr_sh <= {link.tdi, bsr_sh[BSR_W-1:1]};
    end
  end

  // identity register, hardwired value loaded at capture
  always_ff @(posedge link.tck) begin
    if (sys_rst_i) begin
      id_sh <= '0;
    end else if (sel_id && in_cap_dr) begin
      id_sh <= ID_VALUE;
    end else if (sel_id && in_shift_dr) begin
      id_sh <= {link.tdi, id_sh[ID_W-1:1]};
    end
  end

  // the ring belongs to the memory clock; a bit is accepted once two late stages agree.
  // a pin that moves during capture may still show either value, as the port allows.
  always_ff @(posedge link.tck) begin
    if (sys_rst_i) begin
      ring_s1 <= '0;
      ring_s2 <= '0;
      ring_s3 <= '0;
    end else begin
      ring_s1 <= ring_i;
      ring_s2 <= ring_s1;
      ring_s3 <= ring_s2;
    end
  end

  // per bit: take the new level where stages agree, otherwise hold the old one
  always_ff @(posedge link.tck) begin
    if (sys_rst_i) begin
      ring_q <= '0;
    end else begin
      ring_q <= (ring_s2 & ring_s3) | (ring_q & (ring_s2 ^ ring_s3));
    end
  end

  // serial output changes only on the falling test clock
  always_ff @(negedge link.tck) begin
    if (sys_rst_i) begin
      tdo_r <= 1'b0;
    end else begin
      tdo_r <= next_tdo;
    end
  end

  // output enable follows the same edge, so the line never floats mid-bit
  always_ff @(negedge link.tck) begin
    if (sys_rst_i) begin
      tdo_oe_r <= 1'b0;
    end else begin
      tdo_oe_r <= shifting;
    end
  end

  // memory-side status, also on the falling edge so it settles between samples
  always_ff @(negedge link.tck) begin
    if (sys_rst_i) begin
      mem_hiz_o <= 1'b0;
    end else begin
      mem_hiz_o <= hiz_dec;
    end
  end

  always_ff @(negedge link.tck) begin
    if (sys_rst_i) begin
      instr_o <= INS_IDCODE;
    end else begin
      instr_o <= ir;
    end
  end

  assign link.tdo_drv = tdo_r;
  assign link.tdo_oe  = tdo_oe_r;

endmodule : sbst_tap
`default_nettype wire

// file: sbst_host.sv
// test controller end: divides the core clock into the test clock and walks the scan port
`timescale 1ns/1ps
`default_nettype none
module sbst_host #(
  parameter int W    = sbst_pkg::BSR_W,
  parameter int HALF = sbst_pkg::TCK_HALF_CYCLES
) (
  input  wire logic              core_clk_i,
  input  wire logic              sys_rst_i,
  input  wire logic              start_i,
  input  wire sbst_pkg::sbst_op_t op_i,
  input  wire logic [6:0]        len_i,
  input  wire logic [W-1:0]      tx_i,
  output var  logic              busy_o,
  output var  logic              done_o,
  output var  logic [W-1:0]      rx_o,
  sbst_if.host                   link
);
  import sbst_pkg::*;

  logic [7:0]   cnt;
  logic         tck_r;
  logic         tms_r;
  logic         tdi_r;
  logic         oe_r;
  logic         arm;
  logic         cur_shift;
  logic [5:0]   pre_pat;
  logic [2:0]   pre_left;
  logic [6:0]   sh_left;
  logic [1:0]   post_pat;
  logic [1:0]   post_left;
  logic [W-1:0] tx;
  logic         tdo_s1;
  logic         tdo_s2;
  logic         tdo_s3;
  logic         tdo_q;

  wire logic half_end;
  wire logic rise;
  wire logic fall;
  wire logic have_pre;
  wire logic have_sh;
  wire logic have_post;
  wire logic present;
  wire logic next_tms;
  wire logic next_tdi;

  assign half_end  = (cnt == 8'(HALF - 1));
  assign rise      = busy_o && !arm && half_end && !tck_r;
  assign fall      = busy_o && !arm && half_end && tck_r;
  assign have_pre  = (pre_left != 3'h0);
  assign have_sh   = (sh_left != 7'h0);
  assign have_post = (post_left != 2'h0);
  assign present   = arm || (fall && (have_pre || have_sh || have_post));
  // last shifted bit leaves with mode select high, moving to exit1
  assign next_tms  = have_pre ? pre_pat[0] : have_sh ? (sh_left == 7'h1) : post_pat[0];
  assign next_tdi  = !have_pre && have_sh && tx[0];

  // divider and bit sequencer; mode select and data move only while the test clock is low, at a fall or at the start of a walk
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      busy_o    <= 1'b0;
      done_o    <= 1'b0;
      arm       <= 1'b0;
      cnt       <= 8'h0;
      tck_r     <= 1'b0;
      tms_r     <= 1'b1;
      tdi_r     <= 1'b1;
      oe_r      <= 1'b0;
      cur_shift <= 1'b0;
      pre_pat   <= 6'h0;
      pre_left  <= 3'h0;
      sh_left   <= 7'h0;
      post_pat  <= 2'h0;
      post_left <= 2'h0;
      tx        <= '0;
    end else begin
      oe_r   <= 1'b1;
      done_o <= 1'b0;
      if (!busy_o && start_i) begin
        busy_o    <= 1'b1;
        arm       <= 1'b1;
        tx        <= tx_i;
        pre_pat   <= (op_i == SBST_OP_RESET) ? PRE_RESET : (op_i == SBST_OP_IR) ? PRE_IR : PRE_DR;
        pre_left  <= (op_i == SBST_OP_RESET) ? LEN_RESET : (op_i == SBST_OP_IR) ? LEN_IR : LEN_DR;
        sh_left   <= (op_i == SBST_OP_RESET) ? 7'h0 : len_i;
        post_pat  <= POST_PAT;
        post_left <= (op_i == SBST_OP_RESET) ? 2'h0 : LEN_POST;
      end
      if (busy_o && !arm) begin
        cnt <= half_end ? 8'h0 : cnt + 8'h1;
        if (half_end) tck_r <= !tck_r;
      end
      if (present) begin
        arm       <= 1'b0;
        cnt       <= 8'h0;
        tms_r     <= next_tms;
        tdi_r     <= next_tdi;
        cur_shift <= !have_pre && have_sh;
        if (have_pre) begin
          pre_pat  <= pre_pat >> 1;
          pre_left <= pre_left - 3'h1;
        end else if (have_sh) begin
          tx      <= tx >> 1;
          sh_left <= sh_left - 7'h1;
        end else begin
          post_pat  <= post_pat >> 1;
          post_left <= post_left - 2'h1;
        end
      end else if (fall) begin
        busy_o    <= 1'b0;
        done_o    <= 1'b1;
        tms_r     <= 1'b0;
        cur_shift <= 1'b0;
      end
    end
  end

  // returned data enters lsb first into the top of rx
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      tdo_s1 <= 1'b1;
      tdo_s2 <= 1'b1;
      tdo_s3 <= 1'b1;
      tdo_q  <= 1'b1;
      rx_o   <= '0;
    end else begin
      tdo_s1 <= link.tdo;
      tdo_s2 <= tdo_s1;
      tdo_s3 <= tdo_s2;
      if (tdo_s2 == tdo_s3) tdo_q <= tdo_s2;
      if (rise && cur_shift) rx_o <= {tdo_q, rx_o[W-1:1]};
    end
  end

  // reserved instruction codes are the caller's duty: tx_i is sent as given
  assign link.tck     = tck_r;
  assign link.tms_drv = tms_r;
  assign link.tms_oe  = oe_r;
  assign link.tdi_drv = tdi_r;
  assign link.tdi_oe  = oe_r;

endmodule : sbst_host
`default_nettype wire

// file: sbst_checker.sv
// concurrent checks on the scan link between the test controller and the memory scan port
`timescale 1ns/1ps
`default_nettype none
module sbst_checker #(
  parameter logic [sbst_pkg::ID_W-1:0] ID_VALUE = sbst_pkg::ID_DEFAULT
) (
  input wire logic tck,
  input wire logic sys_rst_i,
  input wire logic tms,
  input wire logic tdi,
  input wire logic tdo_drv,
  input wire logic tdo_oe
);
  import sbst_pkg::*;
  sbst_tap_t        st;
  sbst_tap_t        next_st;
  logic [IR_W-1:0]  ir_sr;
  logic [IR_W-1:0]  ir;
  logic [7:0]       run;
  logic [BSR_W-1:0] hist;
  wire logic in_shift = (st == ST_SHIFT_DR) || (st == ST_SHIFT_IR);
  wire logic bsr_sel  = (ir == INS_EXTEST) || (ir == INS_SAMPLE_Z) || (ir == INS_SAMPLE);
  wire logic byp_sel  = !bsr_sel && (ir != INS_IDCODE);

  // reference controller, followed from the wires alone
  always_comb begin
    case (st)
      ST_RESET:                      next_st = tms ? ST_RESET : ST_IDLE;
      ST_IDLE, ST_UPD_DR, ST_UPD_IR: next_st = tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR:                     next_st = tms ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR, ST_SHIFT_DR:        next_st = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR:                   next_st = tms ? ST_UPD_DR : ST_PAUSE_DR;
      ST_PAUSE_DR:                   next_st = tms ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR:                   next_st = tms ? ST_UPD_DR : ST_SHIFT_DR;
      ST_SEL_IR:                     next_st = tms ? ST_RESET : ST_CAP_IR;
      ST_CAP_IR, ST_SHIFT_IR:        next_st = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR:                   next_st = tms ? ST_UPD_IR : ST_PAUSE_IR;
      ST_PAUSE_IR:                   next_st = tms ? ST_EXIT2_IR : ST_PAUSE_IR;
      default:                       next_st = tms ? ST_UPD_IR : ST_SHIFT_IR;
    endcase
  end

  always_ff @(posedge tck) begin
    if (sys_rst_i) begin
      st    <= ST_RESET;
      ir    <= INS_IDCODE;
      ir_sr <= IR_CAPTURE;
      run   <= 8'h00;
      hist  <= '0;
    end else begin
      st    <= next_st;
      hist  <= {hist[BSR_W-2:0], tdi};
      run   <= in_shift ? run + 8'h01 : 8'h00;
      if (st == ST_CAP_IR) ir_sr <= IR_CAPTURE;
      if (st == ST_SHIFT_IR) ir_sr <= {tdi, ir_sr[IR_W-1:1]};
      if (st == ST_UPD_IR) ir <= ir_sr;
      if (st == ST_RESET) ir <= INS_IDCODE;
    end
  end

  tdo_oe_shift_a: assert property (@(posedge tck) disable iff (sys_rst_i) tdo_oe == in_shift)
    else $error("serial out enable differs from shift state");
  oe_fall_edge_a: assert property (@(negedge tck) disable iff (sys_rst_i) tdo_oe == $past(in_shift))
    else $error("serial out enable not moved on falling edge");
  ir_capture_a: assert property (@(posedge tck) disable iff (sys_rst_i)
    (st == ST_SHIFT_IR && run < 8'h02) |-> tdo_drv == IR_CAPTURE[run[0]])
    else $error("captured instruction pattern wrong");
  ir_length_a: assert property (@(posedge tck) disable iff (sys_rst_i)
    (st == ST_SHIFT_IR && run >= 8'h03) |-> tdo_drv == hist[2])
    else $error("instruction path length wrong");
  id_code_a: assert property (@(posedge tck) disable iff (sys_rst_i)
    (st == ST_SHIFT_DR && ir == INS_IDCODE && run < 8'h20) |-> tdo_drv == ID_VALUE[run[4:0]])
    else $error("identity bit wrong");
  bypass_bit_a: assert property (@(posedge tck) disable iff (sys_rst_i)
    (st == ST_SHIFT_DR && byp_sel) |-> tdo_drv == ((run == 8'h00) ? 1'b0 : hist[0]))
    else $error("bypass path wrong");
  chain_length_a: assert property (@(posedge tck) disable iff (sys_rst_i)
    (st == ST_SHIFT_DR && bsr_sel && run >= 8'h4b) |-> tdo_drv == hist[74])
    else $error("boundary chain length wrong");
  tms_reset_a: assert property (@(posedge tck) disable iff (sys_rst_i) tms [*5] |=> !tdo_oe)
    else $error("serial out driven after mode-select reset");
endmodule : sbst_checker
`default_nettype wire

// file: tb_sram_boundary_scan_tap.sv
// bench: the controller end walks the memory scan port through the shared link
`timescale 1ns/1ps
`default_nettype none
module tb_sram_boundary_scan_tap;
  import sbst_pkg::*;
  localparam int W = 80;
  localparam logic [W-1:0] TXP = 80'hc3a5_96e1_7d28_4bf0_1e5a;
  logic             core_clk_i = 1'b0;
  logic             host_rst   = 1'b1;
  logic             tap_rst    = 1'b1;
  logic             start      = 1'b0;
  sbst_op_t         op         = SBST_OP_RESET;
  logic [6:0]       len        = 7'h00;
  logic [W-1:0]     tx         = '0;
  logic [BSR_W-1:0] ring       = '0;
  logic             busy;
  logic             done;
  logic             mem_hiz;
  logic [W-1:0]     rx;
  logic [IR_W-1:0]  instr;
  int               num_errors = 0;
  int               n_tests    = 0;
  int               cycles     = 0;

  sbst_if i_sbst_if ();
  sbst_tap i_sbst_tap (.sys_rst_i(tap_rst), .ring_i(ring), .mem_hiz_o(mem_hiz), .instr_o(instr),
    .link(i_sbst_if));
  sbst_host #(.W(W)) i_sbst_host (.core_clk_i(core_clk_i), .sys_rst_i(host_rst), .start_i(start),
    .op_i(op), .len_i(len), .tx_i(tx), .busy_o(busy), .done_o(done), .rx_o(rx), .link(i_sbst_if));
  sbst_checker i_sbst_checker (.tck(i_sbst_if.tck), .sys_rst_i(tap_rst), .tms(i_sbst_if.tms),
    .tdi(i_sbst_if.tdi), .tdo_drv(i_sbst_if.tdo_drv), .tdo_oe(i_sbst_if.tdo_oe));

  always #10 core_clk_i = ~core_clk_i;

  task automatic final_report();
    if (num_errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : final_report

  task automatic chk_v(input logic [W-1:0] got, input logic [W-1:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk_v

  // one whole controller walk; start is held for exactly one taking edge
  task automatic run(input sbst_op_t o, input logic [6:0] n, input logic [W-1:0] t);
    int k;
    @(posedge core_clk_i);
    #1;
    start = 1'b1;
    op = o;
    len = n;
    tx = t;
    @(posedge core_clk_i);
    #1;
    start = 1'b0;
    chk_v(W'(busy), W'(1'b1));
    for (k = 0; k < 3000 && done !== 1'b1; k++) begin
      @(posedge core_clk_i);
      #1;
    end
    chk_v(W'(done), W'(1'b1));
    chk_v(W'(busy), W'(1'b0));
  endtask : run

  function automatic logic [BSR_W-1:0] ring_of(input logic [2:0] c);
    return {25{c}} ^ {5{15'h2c6b}};
  endfunction : ring_of

  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      final_report();
    end
  end

  initial begin
    logic [2:0] c;
    repeat (6) @(posedge core_clk_i);
    #1;
    host_rst = 1'b0;
    // the port's reset needs test clock edges, so the first walk runs under it
    run(SBST_OP_RESET, 7'h00, '0);
    tap_rst = 1'b0;
    run(SBST_OP_RESET, 7'h00, '0);
    chk_v(W'(instr), W'(INS_IDCODE));
    chk_v(W'(i_sbst_if.tdo), W'(1'b1));
    // descending so the run ends under the all-zero code, outputs floated
    for (int i = 7; i >= 0; i--) begin
      c = 3'(i);
      ring = ring_of(c);
      run(SBST_OP_IR, 7'h06, {74'h0, c, 3'h0});
      chk_v(rx >> (W - 6), W'(6'h01));
      chk_v(W'(instr), W'(c));
      chk_v(W'(mem_hiz), W'(c == INS_EXTEST || c == INS_SAMPLE_Z));
      if (c == INS_IDCODE) begin
        run(SBST_OP_DR, 7'h28, TXP);
        chk_v(rx >> (W - 40), W'({TXP[7:0], ID_DEFAULT}));
      end else if (c == INS_EXTEST || c == INS_SAMPLE_Z || c == INS_SAMPLE) begin
        run(SBST_OP_DR, 7'h50, TXP);
        chk_v(rx, {TXP[4:0], ring});
        run(SBST_OP_DR, 7'h50, '0);
        chk_v(rx, {5'h00, ring});
        chk_v(W'(instr), W'(c));
      end else begin
        run(SBST_OP_DR, 7'h04, TXP);
        chk_v(rx >> (W - 4), W'({TXP[2:0], 1'b0}));
      end
    end
    run(SBST_OP_RESET, 7'h00, '0);
    chk_v(W'(instr), W'(INS_IDCODE));
    chk_v(W'(mem_hiz), W'(1'b0));
    final_report();
  end
endmodule : tb_sram_boundary_scan_tap
`default_nettype wire
